//--- core/duic_pkg.sv
// Purpose: constants shared by the interrupt context stage of the dual uart
// Assumes: byte-wide registers on a 32-bit classic wishbone slave
// Notes:   offsets are byte addresses, one aligned word per register

package duic_pkg;

  // ********************************************************************
  // register map
  // ********************************************************************
  localparam logic [7:0] OFF_THRESHOLD = 8'h00; // arbitration threshold, rw
  localparam logic [7:0] OFF_CONTEXT   = 8'h04; // current interrupt context, ro
  localparam logic [7:0] OFF_VECTOR    = 8'h08; // interrupt vector, rw
  localparam logic [7:0] OFF_CHANNEL   = 8'h0c; // interrupting channel, ro
  localparam logic [7:0] OFF_BYTECNT   = 8'h10; // interrupting byte count, ro
  localparam logic [7:0] OFF_TYPE      = 8'h14; // interrupting type, ro
  localparam logic [7:0] OFF_CHIPCFG   = 8'h18; // global chip config, rw
  localparam logic [7:0] OFF_RXWIN     = 8'h1c; // global receive window, ro
  localparam logic [7:0] OFF_TXWIN     = 8'h20; // global transmit window, wo
  localparam logic [7:0] OFF_IRQ_STS   = 8'h24; // event status, write one to clear
  localparam logic [7:0] OFF_IRQ_MSK   = 8'h28; // event mask, rw
  localparam logic [7:0] OFF_BID_BASE  = 8'h40; // bid control, one word per kind
  localparam logic [7:0] OFF_UPDATE    = 8'h8c; // context update command

  // ********************************************************************
  // field layout and reset values
  // ********************************************************************
  localparam int          NUM_KIND     = 9;     // rx, tx and seven other causes
  localparam int          KIND_RX      = 0;
  localparam int          KIND_TX      = 1;
  localparam int          KIND_WDOG    = 5;     // other cause code 4
  localparam int          NUM_OTHER    = 7;
  localparam int          CHAN_BITS    = 3;     // low bits of an arbitration number
  localparam logic [7:0]  CTX_NONE     = 8'h00;
  localparam logic [1:0]  CLS_OTHER    = 2'b00;
  localparam logic [1:0]  CLS_TX       = 2'b01;
  localparam logic [1:0]  CLS_RX_OK    = 2'b10;
  localparam logic [1:0]  CLS_RX_ERR   = 2'b11;
  localparam logic [4:0]  CNT_ONE      = 5'h00; // at least one character
  localparam logic [4:0]  CNT_SIXTEEN  = 5'h01; // at least sixteen characters
  localparam logic [7:0]  LEVEL_COARSE = 8'h10;
  localparam logic [1:0]  VCF_OFF      = 2'b00;
  localparam logic [1:0]  VCF_PLAIN    = 2'b01;
  localparam logic [1:0]  VCF_TYPE     = 2'b11;
  localparam logic [7:0]  RST_BYTE     = 8'h00;
  localparam logic [7:0]  TYPE_TX      = 8'h20;
  localparam logic [7:0]  TYPE_RX_ERR  = 8'h80;
  localparam logic [7:0]  TYPE_RX_OK   = 8'hc0;
  localparam int          EV_CAPTURE   = 0;
  localparam int          EV_REQUEST   = 1;
  localparam int          NUM_EV       = 2;

endpackage

//--- core/duic_top.sv
// Purpose: interrupt arbitration output stage and captured context of a dual uart
// Assumes: source pending flags and fifo levels come from logic on CLOCK
// Notes:   levels code 1..255 directly and 0 as 256
//
// Overview of operation
// RULE_01: request pin low only while winning bid strictly exceeds the threshold
// RULE_02: threshold is one unsigned byte against bid bits above three channel bits
// RULE_03: capture with winner not above threshold stores all zero context
// RULE_04: pending watchdog drops threshold, only receiver sources arbitrate
// RULE_05: any write to the update address captures the winner, stores nothing
// RULE_06: start of acknowledge cycle captures the winning arbitration value
// RULE_07: arbitration runs on, captured context frozen until next capture
// RULE_08: context bits 7:6 give class other, transmit, receive with or without errors
// RULE_09: other class bits 5:1 give the cause code one to seven
// RULE_10: transmit or receive bits 5:1 give coarse count, one or sixteen
// RULE_11: context bit 0 names channel or counter instance
// RULE_12: context low bit steers global registers and fifo windows
// RULE_13: vector byte driven on data bus during acknowledge when configured
// RULE_14: vector keeps bits 7:3, type in 2:1 when field 3, channel when above 1
// RULE_15: channel register returns captured channel in bit 0, rest zero
// RULE_16: byte count holds level sampled at capture, zero meaning 256
// RULE_17: each source bid takes its eight upper bits from a bid control register
// RULE_18: host writes transmit window only while context is a transmit interrupt; the code pulses the window write in any context
// RULE_19: request re-evaluated every clock, released when no bid exceeds threshold
//
// The Wishbone register port and the address map were chosen for this implementation.

`timescale 1ns/1ps
`default_nettype none

module duic_top
  import duic_pkg::*;
(
  input  wire logic        CLOCK,
  input  wire logic        RST_N,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  input  wire logic [1:0]  RX_PEND,
  input  wire logic [1:0]  RX_ERR,
  input  wire logic [1:0]  TX_PEND,
  input  wire logic [13:0] OTHER_PEND,
  input  wire logic [15:0] RX_FILL_LEVEL,
  input  wire logic [15:0] TX_EMPTY_LEVEL,
  input  wire logic [15:0] RX_DATA,
  input  wire logic        INTERRUPT_ACKNOWLEDGE_N,
  output logic             INTERRUPT_REQUEST_N,
  output logic      [7:0]  VECTOR_DATA,
  output logic             VECTOR_OE,
  output logic             FIFO_CHANNEL,
  output logic             RX_WINDOW_READ,
  output logic             TX_WINDOW_WRITE,
  output logic      [7:0]  TX_WINDOW_DATA,
  output logic             SYS_IRQ
);

  // ********************************************************************
  // state
  // ********************************************************************
  typedef struct packed {
    logic [7:0]                thr;
    logic [7:0]                ctx;
    logic [7:0]                vec;
    logic [1:0]                vcf;
    logic [7:0]                bcnt;
    logic [7:0]                itype;
    logic [NUM_KIND-1:0][7:0]  bid;
    logic [NUM_EV-1:0]         sts;
    logic [NUM_EV-1:0]         msk;
    logic                      ack;
    logic [7:0]                rdat;
    logic                      iack_s1;
    logic                      iack_s2;
    logic                      iack_d;
    logic                      irq_n;
    logic [7:0]                vdat;
    logic                      voe;
    logic                      tx_wr;
    logic [7:0]                tx_dat;
    logic                      rx_rd;
  } duic_state_s;

  duic_state_s st_r;
  duic_state_s st_nxt;

  logic [7:0] win_bid;
  logic       win_ok;
  logic       wd_c;
  logic       req_c;
  logic       cap_c;
  logic [7:0] cap_ctx;
  logic [7:0] cap_cnt;
  logic [7:0] cap_type;
  logic       bus_req;
  logic       bus_wr;
  logic       bus_rd;

  // ********************************************************************
  // bus decode
  // ********************************************************************
  // write and read side effects land on the edge where ack is seen high
  assign bus_req = WB_CYC_I & WB_STB_I;
  assign bus_wr  = bus_req & WB_WE_I & st_r.ack;
  assign bus_rd  = bus_req & ~WB_WE_I & st_r.ack;

  // ********************************************************************
  // arbitration
  // ********************************************************************
  // scans every kind of both channels; strict compare keeps the earliest on a tie
  always_comb begin
    logic [10:0] num;
    logic [10:0] best;
    logic        pend;
    logic        elig;
    logic [7:0]  lvl;
    num      = '0;
    best     = '0;
    pend     = 1'b0;
    elig     = 1'b0;
    lvl      = '0;
    win_ok   = 1'b0;
    cap_ctx  = CTX_NONE;
    cap_cnt  = RST_BYTE;
    cap_type = RST_BYTE;
    wd_c     = OTHER_PEND[KIND_WDOG-2] | OTHER_PEND[NUM_OTHER+KIND_WDOG-2];
    for (int ch = 0; ch < 2; ch++) begin
      for (int k = 0; k < NUM_KIND; k++) begin
        if (k == KIND_RX) begin
          pend = RX_PEND[ch];
          lvl  = RX_FILL_LEVEL[ch*8 +: 8];
        end else if (k == KIND_TX) begin
          pend = TX_PEND[ch];
          lvl  = TX_EMPTY_LEVEL[ch*8 +: 8];
        end else begin
          pend = OTHER_PEND[ch*NUM_OTHER + k - 2];
          lvl  = RST_BYTE;
        end
        // RULE_04: watchdog override
        elig = pend & (~wd_c | (k == KIND_RX));
        // RULE_17: bid from control register
        // RULE_02: channel in low three bits
        num = {st_r.bid[k], CHAN_BITS'(ch)};
        if (elig && (!win_ok || num > best)) begin
          win_ok = 1'b1;
          best   = num;
          // RULE_08: class in bits 7:6
          // RULE_10: coarse count code
          // RULE_11: instance in bit 0
          if (k == KIND_RX) begin
            cap_ctx  = {RX_ERR[ch] ? CLS_RX_ERR : CLS_RX_OK,
                        (lvl >= LEVEL_COARSE || lvl == RST_BYTE) ? CNT_SIXTEEN : CNT_ONE,
                        1'(ch)};
            cap_type = RX_ERR[ch] ? TYPE_RX_ERR : TYPE_RX_OK;
          end else if (k == KIND_TX) begin
            cap_ctx  = {CLS_TX,
                        (lvl >= LEVEL_COARSE || lvl == RST_BYTE) ? CNT_SIXTEEN : CNT_ONE,
                        1'(ch)};
            cap_type = TYPE_TX;
          end else begin
            // RULE_09: cause code from kind
            cap_ctx  = {CLS_OTHER, 5'(k - 1), 1'(ch)};
            cap_type = 8'(k - 1);
          end
          // RULE_16: level sampled for count
          cap_cnt = lvl;
        end
      end
    end
    win_bid = best[10:3];
    // RULE_01: strict compare against threshold
    req_c = win_ok & (wd_c | (win_bid > st_r.thr));
    // RULE_03: nothing above threshold captures zero
    if (!req_c) begin
      cap_ctx  = CTX_NONE;
      cap_cnt  = RST_BYTE;
      cap_type = RST_BYTE;
    end
  end

  // ********************************************************************
  // next state
  // ********************************************************************
  always_comb begin
    logic [NUM_EV-1:0] ev;
    logic [NUM_EV-1:0] clr;
    ev     = '0;
    clr    = '0;
    st_nxt = st_r;
    // acknowledge pin passes two flops before any use
    st_nxt.iack_s1 = INTERRUPT_ACKNOWLEDGE_N;
    st_nxt.iack_s2 = st_r.iack_s1;
    st_nxt.iack_d  = st_r.iack_s2;
    // RULE_06: falling acknowledge starts a capture
    // RULE_05: update command captures too
    cap_c = (st_r.iack_d & ~st_r.iack_s2) | (bus_wr && WB_ADR_I == OFF_UPDATE);
    // RULE_07: context only changes on capture
    if (cap_c) begin
      st_nxt.ctx   = cap_ctx;
      st_nxt.bcnt  = cap_cnt;
      st_nxt.itype = cap_type;
    end
    // RULE_19: request re-evaluated each clock
    st_nxt.irq_n = ~req_c;
    // RULE_14: vector modification
    st_nxt.vdat = st_r.vec;
    if (st_r.vcf == VCF_TYPE) begin
      st_nxt.vdat[2:1] = st_r.ctx[7:6];
    end
    if (st_r.vcf > VCF_PLAIN) begin
      st_nxt.vdat[0] = st_r.ctx[0];
    end
    // RULE_13: drive vector during acknowledge
    st_nxt.voe = ~st_r.iack_s2 & (st_r.vcf != VCF_OFF);
    // classic single cycle: ack one cycle after request, dropped the cycle after
    st_nxt.ack   = bus_req & ~st_r.ack;
    st_nxt.tx_wr = 1'b0;
    st_nxt.rx_rd = 1'b0;
    if (bus_req && !st_r.ack) begin
      unique case (WB_ADR_I)
        OFF_THRESHOLD: st_nxt.rdat = st_r.thr;
        OFF_CONTEXT:   st_nxt.rdat = st_r.ctx;
        OFF_VECTOR:    st_nxt.rdat = st_r.vec;
        // RULE_15: channel in bit 0
        OFF_CHANNEL:   st_nxt.rdat = {7'h00, st_r.ctx[0]};
        OFF_BYTECNT:   st_nxt.rdat = st_r.bcnt;
        OFF_TYPE:      st_nxt.rdat = st_r.itype;
        OFF_CHIPCFG:   st_nxt.rdat = {5'h00, st_r.vcf, 1'b0};
        // RULE_12: window steered by context
        OFF_RXWIN:     st_nxt.rdat = RX_DATA[st_r.ctx[0]*8 +: 8];
        OFF_IRQ_STS:   st_nxt.rdat = 8'(st_r.sts);
        OFF_IRQ_MSK:   st_nxt.rdat = 8'(st_r.msk);
        default: begin
          st_nxt.rdat = RST_BYTE;
          for (int k = 0; k < NUM_KIND; k++) begin
            if (WB_ADR_I == OFF_BID_BASE + 8'(4 * k)) begin
              st_nxt.rdat = st_r.bid[k];
            end
          end
        end
      endcase
    end
    if (bus_rd && WB_ADR_I == OFF_RXWIN) begin
      st_nxt.rx_rd = 1'b1;
    end
    if (bus_wr && WB_SEL_I[0]) begin
      unique case (WB_ADR_I)
        OFF_THRESHOLD: st_nxt.thr = WB_DAT_I[7:0];
        OFF_VECTOR:    st_nxt.vec = WB_DAT_I[7:0];
        OFF_CHIPCFG:   st_nxt.vcf = WB_DAT_I[2:1];
        // RULE_12: transmit window write steered by context
        OFF_TXWIN: begin
          st_nxt.tx_wr  = 1'b1;
          st_nxt.tx_dat = WB_DAT_I[7:0];
        end
        OFF_IRQ_STS:   clr = WB_DAT_I[NUM_EV-1:0];
        OFF_IRQ_MSK:   st_nxt.msk = WB_DAT_I[NUM_EV-1:0];
        default: begin
          for (int k = 0; k < NUM_KIND; k++) begin
            if (WB_ADR_I == OFF_BID_BASE + 8'(4 * k)) begin
              st_nxt.bid[k] = WB_DAT_I[7:0];
            end
          end
        end
      endcase
    end
    // sticky events; a set in the clearing cycle survives
    ev[EV_CAPTURE] = cap_c;
    ev[EV_REQUEST] = st_r.irq_n & req_c;
    st_nxt.sts     = (st_r.sts & ~clr) | ev;
  end

  // ********************************************************************
  // registers
  // ********************************************************************
  // acknowledge sync flops reset high so no false capture follows reset
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      st_r         <= '0;
      st_r.iack_s1 <= 1'b1;
      st_r.iack_s2 <= 1'b1;
      st_r.iack_d  <= 1'b1;
      st_r.irq_n   <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ********************************************************************
  // outputs
  // ********************************************************************
  assign WB_DAT_O            = {24'h000000, st_r.rdat};
  assign WB_ACK_O            = st_r.ack;
  assign INTERRUPT_REQUEST_N = st_r.irq_n;
  assign VECTOR_DATA         = st_r.vdat;
  assign VECTOR_OE           = st_r.voe;
  // RULE_12: fifo channel from context
  assign FIFO_CHANNEL        = st_r.ctx[0];
  assign RX_WINDOW_READ      = st_r.rx_rd;
  assign TX_WINDOW_WRITE     = st_r.tx_wr;
  assign TX_WINDOW_DATA      = st_r.tx_dat;
  assign SYS_IRQ             = |(st_r.sts & st_r.msk);

  // ********************************************************************
  // checks
  // ********************************************************************
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);

  sequence iack_fall_seq;
    st_r.iack_d ##0 !st_r.iack_s2;
  endsequence

  sequence update_wr_seq;
    bus_wr && WB_ADR_I == OFF_UPDATE;
  endsequence

  req_thresh_a: assert property ((!wd_c && win_bid <= st_r.thr) |=> INTERRUPT_REQUEST_N) // RULE_01
    else $error("request asserted at or below threshold");
  req_raise_a: assert property ((win_ok && win_bid > st_r.thr) |=> !INTERRUPT_REQUEST_N) // RULE_19
    else $error("request missing above threshold");
  wdog_rx_a: assert property ((wd_c && |RX_PEND) |=> !INTERRUPT_REQUEST_N) // RULE_04
    else $error("watchdog override lost receiver");
  zero_ctx_a: assert property ((cap_c && !req_c) |=> st_r.ctx == CTX_NONE) // RULE_03
    else $error("context not cleared below threshold");
  update_cap_a: assert property (update_wr_seq |=> st_r.ctx == $past(cap_ctx)) // RULE_05
    else $error("update command did not capture");
  iack_cap_a: assert property (iack_fall_seq |=> st_r.ctx == $past(cap_ctx)) // RULE_06
    else $error("acknowledge did not capture");
  ctx_frozen_a: assert property (!cap_c |=> $stable(st_r.ctx)) // RULE_07
    else $error("context changed without capture");
  class_code_a: assert property ((cap_c && req_c && cap_type == TYPE_TX)
                                 |=> st_r.ctx[7:6] == CLS_TX) // RULE_08
    else $error("transmit class wrong");
  chan_read_a: assert property ((bus_req && !st_r.ack && !WB_WE_I && WB_ADR_I == OFF_CHANNEL)
                                |=> WB_DAT_O[7:0] == {7'h00, $past(FIFO_CHANNEL)}) // RULE_15
    else $error("channel register wrong");
  vec_drive_a: assert property (VECTOR_OE |-> !$past(st_r.iack_s2) // RULE_13
                                && $past(st_r.vcf) != VCF_OFF)
    else $error("vector driven outside acknowledge");
  vec_keep_a: assert property (VECTOR_OE |-> VECTOR_DATA[7:3] == $past(st_r.vec[7:3])) // RULE_14
    else $error("vector upper bits modified");
  ack_drop_a: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held two cycles");

endmodule

`default_nettype wire

//--- bench/duic_host_model.sv
// Purpose: host side of the acknowledge handshake for the interrupt context stage
// Assumes: one acknowledge cycle per go pulse, length set by hold
// Notes:   records whether and what vector byte the device offered

`timescale 1ns/1ps
`default_nettype none

module duic_host_model (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       go,
  input  wire logic [4:0] hold,
  input  wire logic       vec_oe,
  input  wire logic [7:0] vec_data,
  output logic            iack_n,
  output logic            done,
  output logic            driven,
  output logic      [7:0] seen
);
  logic [4:0] cnt_r;

  // ******************************************************************
  // acknowledge cycle
  // ******************************************************************
  // hold sets prompt or slow release; the vector is only taken while offered
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      iack_n <= 1'b1;
      cnt_r  <= 5'h00;
      done   <= 1'b0;
      driven <= 1'b0;
      seen   <= 8'h00;
    end else begin
      done <= 1'b0;
      if (go && cnt_r == 5'h00) begin
        iack_n <= 1'b0;
        cnt_r  <= hold;
        driven <= 1'b0;
      end else if (cnt_r != 5'h00) begin
        if (vec_oe) begin
          driven <= 1'b1;
          seen   <= vec_data;
        end
        cnt_r <= cnt_r - 5'h01;
        if (cnt_r == 5'h01) begin
          iack_n <= 1'b1;
          done   <= 1'b1;
        end
      end
    end
  end
endmodule

`default_nettype wire

//--- bench/testbench.sv
// Purpose: self-checking bench of the interrupt context stage
// Assumes: classic wishbone host, one clock, acknowledge from the host model
// Notes:   each scenario is one task; expectations are worked out here

`timescale 1ns/1ps
`default_nettype none

module testbench;
  import duic_pkg::*;
  logic        clock, rst_n, cyc, stb, we, go, iack_n, done, driven;
  logic [7:0]  adr, seen;
  logic [31:0] dat_i, dat_o;
  logic        ack, irq_n, vec_oe, fifo_ch, rxw_rd, txw_wr, sys_irq;
  logic [1:0]  rx_pend, rx_err, tx_pend;
  logic [13:0] other_pend;
  logic [15:0] rx_lvl, tx_lvl, rx_data;
  logic [7:0]  vec_data, txw_dat, tx_last;
  logic [4:0]  hold;
  int          bad_count = 0;
  int          n_checks = 0;
  int          tx_wr_n = 0;
  int          rx_rd_n = 0;

  duic_top u_dut (.CLOCK(clock), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'h1), .WB_DAT_I(dat_i), .WB_DAT_O(dat_o),
    .WB_ACK_O(ack), .RX_PEND(rx_pend), .RX_ERR(rx_err), .TX_PEND(tx_pend),
    .OTHER_PEND(other_pend), .RX_FILL_LEVEL(rx_lvl), .TX_EMPTY_LEVEL(tx_lvl),
    .RX_DATA(rx_data), .INTERRUPT_ACKNOWLEDGE_N(iack_n), .INTERRUPT_REQUEST_N(irq_n),
    .VECTOR_DATA(vec_data), .VECTOR_OE(vec_oe), .FIFO_CHANNEL(fifo_ch),
    .RX_WINDOW_READ(rxw_rd), .TX_WINDOW_WRITE(txw_wr), .TX_WINDOW_DATA(txw_dat),
    .SYS_IRQ(sys_irq));

  duic_host_model u_host (.clock(clock), .rst_n(rst_n), .go(go), .hold(hold),
    .vec_oe(vec_oe), .vec_data(vec_data), .iack_n(iack_n), .done(done),
    .driven(driven), .seen(seen));

  // ******************************************************************
  // clock, monitors and shared tasks
  // ******************************************************************
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // counts window pulses so each access is seen whatever its cycle
  always @(posedge clock) begin
    if (txw_wr === 1'b1) begin
      tx_wr_n <= tx_wr_n + 1;
      tx_last <= txw_dat;
    end
    if (rxw_rd === 1'b1) rx_rd_n <= rx_rd_n + 1;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // request stands until a rising edge samples ack high; read data is taken at that edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                    output logic [7:0] q);
    int i;
    @(posedge clock);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat_i <= {24'h0, d};
    i = 0;
    do begin
      @(posedge clock);
      i++;
    end while (ack !== 1'b1 && i < 50);
    if (ack !== 1'b1) chk(8'h00, 8'h01);
    q = dat_o[7:0];
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    wb(1'b0, a, 8'h00, q);
    chk(q, e);
  endtask

  task automatic settle();
    repeat (3) @(posedge clock);
    @(negedge clock);
  endtask

  // ******************************************************************
  // scenarios
  // ******************************************************************
  task automatic t_reset();
    rdc(OFF_THRESHOLD, 8'h00);
    rdc(OFF_CONTEXT, 8'h00);
    rdc(8'h30, 8'h00);
    chk({7'h0, irq_n}, 8'h01);
  endtask

  task automatic t_threshold();
    wr(OFF_BID_BASE + 8'h04, 8'h20);
    tx_lvl <= 16'h0010;
    tx_pend <= 2'b01;
    wr(OFF_THRESHOLD, 8'h20);
    settle();
    chk({7'h0, irq_n}, 8'h01);
    wr(OFF_UPDATE, 8'h5a);
    rdc(OFF_CONTEXT, 8'h00);
    wr(OFF_IRQ_MSK, 8'h01);
    settle();
    chk({7'h0, sys_irq}, 8'h01);
    wr(OFF_IRQ_STS, 8'h01);
    settle();
    chk({7'h0, sys_irq}, 8'h00);
    rdc(OFF_IRQ_STS, 8'h02);
    wr(OFF_THRESHOLD, 8'h1f);
    settle();
    chk({7'h0, irq_n}, 8'h00);
    wr(OFF_UPDATE, 8'h00);
    rdc(OFF_CONTEXT, 8'h42);
    rdc(OFF_BYTECNT, 8'h10);
    rdc(OFF_CHANNEL, 8'h00);
    rdc(OFF_TYPE, TYPE_TX);
    wr(OFF_TXWIN, 8'h5a);
    settle();
    chk(8'(tx_wr_n), 8'h01);
    chk(tx_last, 8'h5a);
  endtask

  task automatic t_freeze();
    wr(OFF_BID_BASE, 8'h40);
    rx_lvl <= 16'h0000;
    rx_err <= 2'b10;
    rx_pend <= 2'b10;
    rx_data <= 16'h3c7e;
    settle();
    rdc(OFF_CONTEXT, 8'h42);
    wr(OFF_UPDATE, 8'h00);
    rdc(OFF_CONTEXT, 8'hc3);
    rdc(OFF_BYTECNT, 8'h00);
    rdc(OFF_CHANNEL, 8'h01);
    chk({7'h0, fifo_ch}, 8'h01);
    rdc(OFF_RXWIN, 8'h3c);
    settle();
    chk(8'(rx_rd_n), 8'h01);
  endtask

  // watchdog cause is left to its own scenario since it changes arbitration
  task automatic t_other();
    int j;
    logic ch;
    rx_pend <= 2'b00;
    tx_pend <= 2'b00;
    for (j = 0; j < 7; j++) if (j != 3) begin
      ch = j[0];
      wr(OFF_BID_BASE + 8'(4 * (2 + j)), 8'h30);
      other_pend <= 14'h0001 << (j + 7 * ch);
      settle();
      wr(OFF_UPDATE, 8'h00);
      rdc(OFF_CONTEXT, {2'b00, 5'(j + 1), ch});
      other_pend <= 14'h0000;
    end
  endtask

  task automatic t_wdog();
    wr(OFF_THRESHOLD, 8'hff);
    wr(OFF_BID_BASE, 8'h01);
    rx_pend <= 2'b01;
    rx_err <= 2'b00;
    rx_lvl <= 16'h0005;
    tx_pend <= 2'b01;
    other_pend <= 14'h0008;
    settle();
    chk({7'h0, irq_n}, 8'h00);
    wr(OFF_UPDATE, 8'h00);
    rdc(OFF_CONTEXT, 8'h80);
    other_pend <= 14'h0000;
    settle();
    chk({7'h0, irq_n}, 8'h01);
  endtask

  task automatic t_vector();
    logic [7:0] exp [4] = '{8'h00, 8'ha8, 8'ha9, 8'haf};
    int v, i;
    wr(OFF_THRESHOLD, 8'h1f);
    wr(OFF_BID_BASE, 8'h40);
    rx_pend <= 2'b10;
    rx_err <= 2'b10;
    rx_lvl <= 16'h0000;
    wr(OFF_VECTOR, 8'ha8);
    for (v = 0; v < 4; v++) begin
      wr(OFF_CHIPCFG, {5'h00, 2'(v), 1'b0});
      hold <= v[0] ? 5'h0e : 5'h08;
      go <= 1'b1;
      @(posedge clock);
      go <= 1'b0;
      for (i = 0; i < 40 && done !== 1'b1; i++) @(negedge clock);
      if (done !== 1'b1) chk(8'h00, 8'h01);
      chk({7'h0, driven}, {7'h0, v != 0});
      if (v != 0) chk(seen, exp[v]);
      if (v == 0) rdc(OFF_CONTEXT, 8'hc3);
      settle();
      chk({7'h0, vec_oe}, 8'h00);
    end
  endtask

  // ******************************************************************
  // run control
  // ******************************************************************
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    #(100 * 20000);
    bad_count++;
    give_verdict();
  end

  initial begin
    rst_n = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; dat_i = 32'h0;
    rx_pend = 2'b00; rx_err = 2'b00; tx_pend = 2'b00; other_pend = 14'h0000;
    rx_lvl = 16'h0000; tx_lvl = 16'h0000; rx_data = 16'h0000; go = 1'b0; hold = 5'h08;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    t_reset();
    t_threshold();
    t_freeze();
    t_other();
    t_wdog();
    t_vector();
    give_verdict();
  end
endmodule

`default_nettype wire
